// ===== inc/pbg_params.svh
/*
  Offsets, field positions, reset values and lane positions of the peripheral bus glue.
  Assumes the includer compares these against a latched byte address of the glue select space.
*/
`ifndef PBG_PARAMS_SVH
`define PBG_PARAMS_SVH
`define PBG_SID_BASE 24'h000000
`define PBG_SID_MASK 24'hfff000
`define PBG_DISP_BASE 24'h001000
`define PBG_DISP_MASK 24'hfff000
`define PBG_SEG0_ADDR 24'h002000
`define PBG_SEG1_ADDR 24'h002004
`define PBG_SID_HIGH 8'h01
`define PBG_SID_LOW 8'h00
`define PBG_SID_RESET 1'b1
`define PBG_SEG_RESET 8'h00
`define PBG_CARD_IO_BIT 19
`define PBG_LANE16_LSB 16
`define PBG_LANE8_LSB 24
`endif

// ===== inc/pbg_pkg.sv
/*
  Types shared by the peripheral bus glue.
  Assumes pbg_params.svh is on the include path.
*/
package pbg_pkg;
  typedef logic [6:0] pbg_seg_t;
  typedef enum logic [1:0] {PBG_IDLE, PBG_READ, PBG_WRITE} pbg_cycle_t;
endpackage

// ===== verilog/pbg_glue.sv
/*
  Peripheral bus glue: serial-id pin port, card socket strobes and insertion flag,
  character display selects, two latched seven-segment digits.
  Assumes the bus master drives ale, rd_n, wr_n and the selects synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pbg_params.svh"

// What this block does
// [RULE1] Writing 0x01 into the serial-id window drives the pin high; the glue releases it to the outside pull-up instead.
// [RULE2] Writing 0x00 into the serial-id window drives the pin low.
// [RULE3] Reading the serial-id window returns the pin level on data bit zero.
// [RULE4] Bits seven to one of serial-id reads are undefined; host ignores them.
// [RULE5] Card I/O read and write strobes for the upper 512 KB of card space.
// [RULE6] Card insertion while out of reset raises an interrupt.
// [RULE7] The card answers only to the second peripheral select in its range.
// [RULE8] Card memory and I/O accesses over 16 bits; no ATA mode.
// [RULE9] Display range decodes into display select and register select.
// [RULE10] Each digit has its own address; a write updates only that digit.
// [RULE11] Card accesses use the upper 16-bit lane of the bus.
// [RULE12] Display and digit accesses use the top byte lane.
// [RULE13] Digit values are latched and decoded into segment patterns.
// [RULE14] Serial-id pin holds its last value and comes up high.
// [RULE15] Insertion flag holds until acknowledged; detect synchronised first.
module pbg_glue #(
  parameter int ADDR_W = 24
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic glue_select_n,
  input wire logic second_peripheral_select_n,
  input wire logic [31:0] peripheral_addr_data_bus_in,
  output logic [31:0] peripheral_addr_data_bus_out,
  output logic peripheral_addr_data_bus_oe,
  input wire logic serial_id_in,
  output logic serial_id_out,
  output logic serial_id_oe,
  output logic card_io_rd_n,
  output logic card_io_wr_n,
  output logic card_mem_oe_n,
  output logic card_mem_we_n,
  output logic [ADDR_W-1:0] card_addr,
  output logic [15:0] card_data_out,
  output logic card_data_oe,
  input wire logic [15:0] card_data_in,
  input wire logic card_detect_n,
  input wire logic card_irq_ack,
  output logic card_irq,
  output logic display_select_n,
  output logic display_register_select,
  output logic [7:0] display_data,
  output pbg_pkg::pbg_seg_t seg0_segments,
  output pbg_pkg::pbg_seg_t seg1_segments
);
  import pbg_pkg::*;

  logic [ADDR_W-1:0] addr_reg;
  logic wr_n_d_reg;
  logic sid_reg;
  logic [7:0] seg0_reg;
  logic [7:0] seg1_reg;
  logic cd_meta_reg;
  logic cd_sync_reg;
  logic cd_prev_reg;
  logic card_irq_reg;
  logic [7:0] wbyte;
  logic wr_start;
  logic sid_hit;
  logic disp_hit;
  logic card_sel;
  logic card_io;
  pbg_cycle_t cyc;

  // Hex nibble to segments g..a, active high
  function automatic pbg_seg_t hex_seg(input logic [3:0] v);
    unique case (v)
      4'h0: hex_seg = 7'h3f;
      4'h1: hex_seg = 7'h06;
      4'h2: hex_seg = 7'h5b;
      4'h3: hex_seg = 7'h4f;
      4'h4: hex_seg = 7'h66;
      4'h5: hex_seg = 7'h6d;
      4'h6: hex_seg = 7'h7d;
      4'h7: hex_seg = 7'h07;
      4'h8: hex_seg = 7'h7f;
      4'h9: hex_seg = 7'h6f;
      4'ha: hex_seg = 7'h77;
      4'hb: hex_seg = 7'h7c;
      4'hc: hex_seg = 7'h39;
      4'hd: hex_seg = 7'h5e;
      4'he: hex_seg = 7'h79;
      4'hf: hex_seg = 7'h71;
    endcase
  endfunction

  // Address phase of the multiplexed bus
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= '0;
    end else if (ale) begin
      addr_reg <= peripheral_addr_data_bus_in[ADDR_W-1:0];
    end
  end

  // Write edge tracking so a long strobe acts once
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_n_d_reg <= 1'b1;
    end else begin
      wr_n_d_reg <= wr_n;
    end
  end

  // Decode of the glue select space and the card select
  always_comb begin
    wbyte = peripheral_addr_data_bus_in[`PBG_LANE8_LSB +: 8]; // RULE12
    wr_start = !wr_n && wr_n_d_reg && !ale;
    sid_hit = !glue_select_n && ((addr_reg & `PBG_SID_MASK) == `PBG_SID_BASE);
    disp_hit = !glue_select_n && ((addr_reg & `PBG_DISP_MASK) == `PBG_DISP_BASE);
    card_sel = !second_peripheral_select_n; // RULE7
    card_io = addr_reg[`PBG_CARD_IO_BIT]; // RULE5
    if (ale) begin
      cyc = PBG_IDLE;
    end else if (!rd_n) begin
      cyc = PBG_READ;
    end else if (!wr_n) begin
      cyc = PBG_WRITE;
    end else begin
      cyc = PBG_IDLE;
    end
  end

  // Serial-id pin; values other than the two codes are ignored
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sid_reg <= `PBG_SID_RESET; // RULE14
    end else if (wr_start && sid_hit) begin
      if (wbyte == `PBG_SID_HIGH) begin
        sid_reg <= 1'b1; // RULE1
      end else if (wbyte == `PBG_SID_LOW) begin
        sid_reg <= 1'b0; // RULE2
      end
    end
  end

  // Open drain: pull low only, a released pin is pulled high outside
  assign serial_id_out = 1'b0;
  assign serial_id_oe = !sid_reg;

  // Digit latches, each at its own address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seg0_reg <= `PBG_SEG_RESET;
      seg1_reg <= `PBG_SEG_RESET;
    end else if (wr_start && !glue_select_n) begin
      if (addr_reg == `PBG_SEG0_ADDR) begin
        seg0_reg <= wbyte; // RULE10
      end
      if (addr_reg == `PBG_SEG1_ADDR) begin
        seg1_reg <= wbyte; // RULE10
      end
    end
  end

  // Segment drive from flip-flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seg0_segments <= '0;
      seg1_segments <= '0;
    end else begin
      seg0_segments <= hex_seg(seg0_reg[3:0]); // RULE13
      seg1_segments <= hex_seg(seg1_reg[3:0]); // RULE13
    end
  end

  // Display selects and data, one cycle behind the bus
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      display_select_n <= 1'b1;
      display_register_select <= 1'b0;
      display_data <= '0;
    end else begin
      display_select_n <= !(disp_hit && cyc != PBG_IDLE); // RULE9
      display_register_select <= addr_reg[0]; // RULE9
      display_data <= wbyte;
    end
  end

  // Card strobes: upper half of range is I/O space, lower is memory
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      card_io_rd_n <= 1'b1;
      card_io_wr_n <= 1'b1;
      card_mem_oe_n <= 1'b1;
      card_mem_we_n <= 1'b1;
      card_addr <= '0;
      card_data_out <= '0;
      card_data_oe <= 1'b0;
    end else begin
      card_io_rd_n <= !(card_sel && card_io && cyc == PBG_READ); // RULE5
      card_io_wr_n <= !(card_sel && card_io && cyc == PBG_WRITE); // RULE5
      card_mem_oe_n <= !(card_sel && !card_io && cyc == PBG_READ); // RULE8
      card_mem_we_n <= !(card_sel && !card_io && cyc == PBG_WRITE); // RULE8
      card_addr <= addr_reg;
      card_data_out <= peripheral_addr_data_bus_in[`PBG_LANE16_LSB +: 16]; // RULE11
      card_data_oe <= card_sel && cyc == PBG_WRITE;
    end
  end

  // Read data back onto the bus; undefined serial-id bits read as zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      peripheral_addr_data_bus_out <= '0;
      peripheral_addr_data_bus_oe <= 1'b0;
    end else begin
      peripheral_addr_data_bus_out <= '0;
      peripheral_addr_data_bus_oe <= (card_sel || sid_hit) && cyc == PBG_READ;
      if (card_sel) begin
        peripheral_addr_data_bus_out[`PBG_LANE16_LSB +: 16] <= card_data_in; // RULE11
      end else if (sid_hit) begin
        peripheral_addr_data_bus_out[`PBG_LANE8_LSB] <= serial_id_in; // RULE3 RULE4
      end
    end
  end

  // Detect synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cd_meta_reg <= 1'b1;
      cd_sync_reg <= 1'b1;
      cd_prev_reg <= 1'b1;
    end else begin
      cd_meta_reg <= card_detect_n; // RULE15
      cd_sync_reg <= cd_meta_reg;
      cd_prev_reg <= cd_sync_reg;
    end
  end

  // Insertion flag; a new insertion wins over an acknowledge in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      card_irq_reg <= 1'b0;
    end else if (cd_prev_reg && !cd_sync_reg) begin
      card_irq_reg <= 1'b1; // RULE6
    end else if (card_irq_ack) begin
      card_irq_reg <= 1'b0; // RULE15
    end
  end
  assign card_irq = card_irq_reg;

  // Checks
  a_sid_set: assert property (@(posedge mclk) disable iff (!resetn) // RULE1
    wr_start && sid_hit && wbyte == `PBG_SID_HIGH |=> !serial_id_oe) else $error("serial id not released high");
  a_sid_clear: assert property (@(posedge mclk) disable iff (!resetn) // RULE2
    wr_start && sid_hit && wbyte == `PBG_SID_LOW |=> serial_id_oe) else $error("serial id not driven low");
  a_sid_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
    !card_sel && sid_hit && cyc == PBG_READ |=> peripheral_addr_data_bus_out[`PBG_LANE8_LSB] == $past(serial_id_in)
      && peripheral_addr_data_bus_oe) else $error("serial id read value wrong");
  a_sid_hold: assert property (@(posedge mclk) disable iff (!resetn) // RULE14
    !(wr_start && sid_hit) |=> $stable(serial_id_oe)) else $error("serial id changed without write");
  a_card_io: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
    !card_io_rd_n |-> $past(addr_reg[`PBG_CARD_IO_BIT]) && $past(card_sel)) else $error("io strobe outside upper range");
  a_card_sel: assert property (@(posedge mclk) disable iff (!resetn) // RULE7
    second_peripheral_select_n |=> card_io_rd_n && card_io_wr_n && card_mem_oe_n && card_mem_we_n)
    else $error("card strobe without select");
  a_disp_sel: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
    disp_hit && cyc == PBG_WRITE |=> !display_select_n) else $error("display not selected");
  a_seg_only: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
    wr_start && !glue_select_n && addr_reg == `PBG_SEG0_ADDR |=> $stable(seg1_reg))
    else $error("wrong digit written");
  a_seg_decode: assert property (@(posedge mclk) disable iff (!resetn) // RULE13
    wr_start && !glue_select_n && addr_reg == `PBG_SEG1_ADDR && wbyte[3:0] == 4'h1 |-> ##2 seg1_segments == 7'h06)
    else $error("digit decode wrong");
  a_irq_hold: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
    card_irq && !card_irq_ack |=> card_irq) else $error("interrupt dropped before ack");
  a_irq_insert: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
    $fell(card_detect_n) ##1 !card_detect_n |-> ##[2:3] card_irq) else $error("insertion missed");
  c_sid_write: cover property (@(posedge mclk) disable iff (!resetn) wr_start && sid_hit);
  c_card_io: cover property (@(posedge mclk) disable iff (!resetn) !card_io_wr_n);
  c_irq: cover property (@(posedge mclk) disable iff (!resetn) card_irq ##1 !card_irq);
endmodule // pbg_glue
`default_nettype wire

// ===== tb/pbg_host_model.sv
/*
  Host peripheral bus master model for the glue block.
  Assumes the bench calls open and close in turn, one access at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module pbg_host_model (
  input wire logic mclk,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic gs_n,
  output logic cs_n,
  output logic [31:0] bus,
  input wire logic [31:0] bus_rd
);
  initial begin
    {ale, rd_n, wr_n, gs_n, cs_n} = 5'h0f;
    bus = 32'h0;
  end

  // Address phase, then one strobe that stays down until close
  task automatic open(input logic rd, input logic g_n, input logic c_n, input logic [23:0] a,
                      input logic [31:0] d);
    @(negedge mclk);
    ale = 1'b1;
    bus = {8'h00, a};
    gs_n = g_n;
    cs_n = c_n;
    @(negedge mclk);
    ale = 1'b0;
    bus = d;
    rd_n = !rd;
    wr_n = rd;
  endtask

  // Takes read data, then releases; a freed bus shows junk, not old data
  task automatic close(output logic [31:0] q);
    @(negedge mclk);
    q = bus_rd;
    {rd_n, wr_n, gs_n, cs_n} = 4'hf;
    bus = ~bus;
    @(negedge mclk);
  endtask
endmodule // pbg_host_model
`default_nettype wire

// ===== tb/pbg_glue_tb_top.sv
/*
  Bench for the peripheral bus glue: host model on the bus, card and pin driven here.
  Assumes glue outputs are registered one cycle behind the bus strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module pbg_glue_tb_top;
  import pbg_pkg::*;
  // Segment patterns for hex 0..f, bit0 = a
  localparam logic [111:0] HEX = {7'h71, 7'h79, 7'h5e, 7'h39, 7'h7c, 7'h77, 7'h6f, 7'h7f,
    7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};
  logic mclk, resetn, ale, rd_n, wr_n, gs_n, cs_n, bus_oe, sid_oe, det_n, ack, irq;
  logic io_rd_n, io_wr_n, mem_oe_n, mem_we_n, data_oe, dsel_n, drs, sid_out;
  logic [31:0] bus, bus_rd, q;
  logic [23:0] caddr;
  logic [15:0] cdo, cdi;
  logic [7:0] ddata;
  pbg_seg_t s0, s1;
  int n_mismatch = 0;
  int cmp_count = 0;
  // Open-drain pin with pull-up
  wire logic sid_pin = sid_oe ? sid_out : 1'b1;

  pbg_host_model host (.mclk(mclk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .gs_n(gs_n),
    .cs_n(cs_n), .bus(bus), .bus_rd(bus_rd));
  pbg_glue DUT (.mclk(mclk), .resetn(resetn), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .glue_select_n(gs_n), .second_peripheral_select_n(cs_n), .peripheral_addr_data_bus_in(bus),
    .peripheral_addr_data_bus_out(bus_rd), .peripheral_addr_data_bus_oe(bus_oe),
    .serial_id_in(sid_pin), .serial_id_out(sid_out), .serial_id_oe(sid_oe), .card_io_rd_n(io_rd_n),
    .card_io_wr_n(io_wr_n), .card_mem_oe_n(mem_oe_n), .card_mem_we_n(mem_we_n),
    .card_addr(caddr), .card_data_out(cdo), .card_data_oe(data_oe), .card_data_in(cdi),
    .card_detect_n(det_n), .card_irq_ack(ack), .card_irq(irq), .display_select_n(dsel_n),
    .display_register_select(drs), .display_data(ddata), .seg0_segments(s0), .seg1_segments(s1));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One glue space access with a byte on the top lane
  task automatic acc(input logic rd, input logic [23:0] a, input logic [7:0] v);
    host.open(rd, 1'b0, 1'b1, a, {v, 24'h0});
    repeat (2) @(negedge mclk);
    host.close(q);
  endtask

  // Pin port: both levels, window edges, an ignored value
  task automatic t_sid();
    acc(1'b0, 24'h000fff, 8'h00);
    chk("sid_low", sid_pin, 1'b0);
    acc(1'b1, 24'h000800, 8'h00);
    chk("sid_rd0", q[24], 1'b0);
    acc(1'b0, 24'h000123, 8'h05);
    chk("sid_keep", sid_pin, 1'b0);
    acc(1'b0, 24'h000000, 8'h01);
    chk("sid_high", sid_pin, 1'b1);
    host.open(1'b1, 1'b0, 1'b1, 24'h000abc, 32'h0);
    repeat (2) @(negedge mclk);
    chk("sid_oe_rd", bus_oe, 1'b1);
    host.close(q);
    chk("sid_rd1", q[24], 1'b1);
  endtask

  // Every hex value on digit 0, then digit 1 alone
  task automatic t_seg();
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, 24'h002000, 8'h10 + 8'(i));
      chk("seg0", s0, HEX[i*7 +: 7]);
      chk("seg1_kept", s1, 7'h3f);
    end
    acc(1'b0, 24'h002004, 8'hc3);
    chk("seg1", s1, 7'h4f);
    chk("seg0_kept", s0, 7'h71);
    acc(1'b0, 24'h002004, 8'h51);
    chk("seg1_one", s1, 7'h06);
    chk("seg0_still", s0, 7'h71);
  endtask

  // Display write and read with both register selects
  task automatic t_disp();
    for (int r = 0; r < 2; r++) begin
      host.open(r[0], 1'b0, 1'b1, r ? 24'h001ffe : 24'h001001, 32'ha5000000);
      repeat (2) @(negedge mclk);
      chk("dsel", dsel_n, 1'b0);
      chk("drs", drs, !r[0]);
      if (r == 0) chk("ddata", ddata, 8'ha5);
      chk("disp_oe", bus_oe, 1'b0);
      host.close(q);
      chk("dsel_off", dsel_n, 1'b1);
    end
  endtask

  // Card: io and memory, read and write, then one access without its select
  task automatic t_card();
    logic io, rd, sel;
    logic [3:0] exp;
    logic [23:0] a;
    for (int i = 0; i < 5; i++) begin
      rd = i[0];
      io = (i < 2) || (i == 4);
      sel = (i != 4);
      a = io ? (24'h0fff00 | 24'(i)) : (24'h07ff00 | 24'(i));
      cdi = 16'hc3a5 ^ 16'(i);
      exp = 4'hf;
      if (sel) exp[(io ? 2 : 0) + (rd ? 1 : 0)] = 1'b0;
      host.open(rd, 1'b1, !sel, a, {16'hbe00 | 16'(i), 16'h0});
      repeat (2) @(negedge mclk);
      chk("strobes", {io_rd_n, io_wr_n, mem_oe_n, mem_we_n}, exp);
      if (sel) chk("caddr", caddr, a);
      chk("cdoe", data_oe, sel && !rd);
      chk("card_oe", bus_oe, sel && rd);
      if (sel && !rd) chk("cdo", cdo, 16'hbe00 | 16'(i));
      host.close(q);
      if (sel && rd) chk("card_rd", q[31:16], cdi);
    end
  endtask

  // Insertion raises the flag, it holds, ack clears it
  task automatic t_irq();
    det_n = 1'b0;
    @(negedge mclk);
    chk("irq_sync", irq, 1'b0);
    for (int k = 0; k < 8 && irq !== 1'b1; k++) @(negedge mclk);
    chk("irq_rise", irq, 1'b1);
    if (irq !== 1'b1) test_done();
    repeat (5) @(negedge mclk);
    chk("irq_hold", irq, 1'b1);
    ack = 1'b1;
    @(negedge mclk);
    ack = 1'b0;
    @(negedge mclk);
    chk("irq_clr", irq, 1'b0);
  endtask

  initial begin
    resetn = 1'b0;
    det_n = 1'b1;
    ack = 1'b0;
    cdi = 16'h0;
    repeat (2) @(negedge mclk);
    chk("rst_out", {sid_oe, irq, bus_oe, io_rd_n, io_wr_n, mem_oe_n, mem_we_n, dsel_n}, 8'h1f);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    chk("seg_rst", s0, 7'h3f);
    chk("sid_rst", sid_pin, 1'b1);
    t_sid();
    t_seg();
    t_disp();
    t_card();
    t_irq();
    test_done();
  end
endmodule // pbg_glue_tb_top
`default_nettype wire
